//--- rtl/rsf_regs.vh
// Register offsets, field positions, reset values and constants of the range-sum and function unit.
`ifndef RSF_REGS_VH
`define RSF_REGS_VH
`define RSF_CMD        8'h00
`define RSF_CTRL       8'h04
`define RSF_SRC        8'h08
`define RSF_DST        8'h0C
`define RSF_STAT       8'h10
`define RSF_MADR       8'h14
`define RSF_MDAT       8'h18
`define RSF_CMD_GO     0
`define RSF_CMD_OP     1
`define RSF_CMD_EXEC   2
`define RSF_CTRL_ISADR 16
`define RSF_OP_IND     15
`define RSF_C_SKIP     12
`define RSF_C_BYTE     13
`define RSF_C_BIN      14
`define RSF_C_SGN      15
`define RSF_H_REFL     13
`define RSF_H_OBIN     14
`define RSF_H_IBIN     15
`define RSF_ST_ERR     0
`define RSF_ST_ZERO    1
`define RSF_ST_NEG     2
`define RSF_ST_BUSY    3
`define RSF_CTRL_RST   17'h0_0000
`define RSF_WORD_RST   16'h0000
`define RSF_ANG_MAX    16'h0384
`define RSF_BCD_MAX    16'h270F
`define RSF_ONE        32'h0100_0000
`define RSF_RAD_TENTH  32'h0000_7262
`define RSF_R72        32'h0003_8E39
`define RSF_R42        32'h0006_1862
`define RSF_R20        32'h000C_CCCD
`define RSF_R6         32'h002A_AAAB
`define RSF_OKAY       2'h0
`define RSF_SLVERR     2'h2
`endif

//--- rtl/rsf_unit.v
// Range summation and arithmetic process unit with its data memory and AXI4-Lite slave.
`timescale 1ns/1ns
`include "rsf_regs.vh"

module rsf_unit #(
    parameter MEM_AW  = 8,
    parameter AREA_AW = 6
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

localparam MEM_D = 1 << MEM_AW;
localparam [8:0] S_IDLE  = 9'h001;
localparam [8:0] S_SETUP = 9'h002;
localparam [8:0] S_SUM   = 9'h004;
localparam [8:0] S_SFIN  = 9'h008;
localparam [8:0] S_TRIG  = 9'h010;
localparam [8:0] S_SCAN  = 9'h020;
localparam [8:0] S_DIV   = 9'h040;
localparam [8:0] S_PFIN  = 9'h080;
localparam [8:0] S_WR    = 9'h100;

reg [15:0] mem [0:MEM_D-1];

function is_bcd(input [15:0] v);
    begin
        is_bcd = (v[15:12] < 4'hA) && (v[11:8] < 4'hA) && (v[7:4] < 4'hA) && (v[3:0] < 4'hA);
    end
endfunction

function [15:0] bcd2bin(input [15:0] v);
    begin
        bcd2bin = v[15:12] * 16'h03E8 + v[11:8] * 16'h0064 + v[7:4] * 16'h000A + {12'h000, v[3:0]};
    end
endfunction

function [31:0] bin2bcd(input [26:0] v);
    reg [58:0] s;
    integer k;
    integer j;
    begin
        s = {32'h0000_0000, v};
        for (k = 0; k < 27; k = k + 1) begin
            for (j = 0; j < 8; j = j + 1) begin
                if (s[27+4*j +: 4] > 4'h4)
                    s[27+4*j +: 4] = s[27+4*j +: 4] + 4'h3;
            end
            s = s << 1;
        end
        bin2bcd = s[58:27];
    end
endfunction

// Returns {ok, address}; an indirect operand holds the address of a BCD pointer word.
function [16:0] resolve(input [15:0] op);
    reg [15:0] w;
    reg [15:0] a;
    begin
        w = mem[op[MEM_AW-1:0]];
        a = bcd2bin(w);
        if (!op[`RSF_OP_IND])
            resolve = {op[14:0] < MEM_D, 1'b0, op[14:0]};
        else
            resolve = {(op[14:0] < MEM_D) && is_bcd(w) && (a < MEM_D), a};
    end
endfunction

function [31:0] merge(input [31:0] old, input [31:0] d, input [3:0] s);
    reg [31:0] m;
    begin
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        merge = (old & ~m) | (d & m);
    end
endfunction

reg  [8:0]  state_reg;
reg  [16:0] ctrl_reg;
reg  [15:0] src_reg;
reg  [15:0] dst_reg;
reg  [15:0] madr_reg;
reg         exec_reg;
reg         op_reg;
reg  [15:0] a_src_reg;
reg  [15:0] a_dst_reg;
reg  [15:0] c_reg;
reg  [15:0] hdr_reg;
reg  [15:0] n_reg;
reg  [15:0] cnt_reg;
reg  [31:0] acc_reg;
reg  [31:0] x_reg;
reg  [31:0] x2_reg;
reg  [31:0] num_reg;
reg  [16:0] rem_reg;
reg  [15:0] den_reg;
reg  [15:0] yb_reg;
reg         dneg_reg;
reg  [15:0] res_lo_reg;
reg  [15:0] res_hi_reg;
reg         two_reg;
reg         err_reg;
reg         zero_reg;
reg         neg_reg;
reg         aw_got_reg;
reg         w_got_reg;
reg  [7:0]  awaddr_reg;
reg  [31:0] wdata_reg;
reg  [3:0]  wstrb_reg;
reg  [31:0] mul_a;
reg  [31:0] mul_b;
reg  [31:0] recip;

wire        busy = (state_reg != S_IDLE);
wire        do_wr = aw_got_reg & w_got_reg & ~s_axi_bvalid;
wire        wr_map = (awaddr_reg == `RSF_CMD) || (awaddr_reg == `RSF_CTRL) || (awaddr_reg == `RSF_SRC) ||
                     (awaddr_reg == `RSF_DST) || (awaddr_reg == `RSF_MADR) || (awaddr_reg == `RSF_MDAT);
// Operand registers and memory stay frozen while an operation runs, so the datapath may read them live.
wire        wr_ok = wr_map && (!busy || awaddr_reg == `RSF_CMD || awaddr_reg == `RSF_MADR);
wire        start = do_wr && wr_ok && awaddr_reg == `RSF_CMD && wstrb_reg[0] && wdata_reg[`RSF_CMD_GO];
wire [31:0] mem_rd = {16'h0000, mem[madr_reg[MEM_AW-1:0]]};
wire [31:0] mdat_new = merge(mem_rd, wdata_reg, wstrb_reg);
wire [31:0] ctrl_new = merge({15'h0000, ctrl_reg}, wdata_reg, wstrb_reg);
wire [31:0] src_new  = merge({16'h0000, src_reg}, wdata_reg, wstrb_reg);
wire [31:0] dst_new  = merge({16'h0000, dst_reg}, wdata_reg, wstrb_reg);
wire [31:0] madr_new = merge({16'h0000, madr_reg}, wdata_reg, wstrb_reg);

wire [63:0] mul_p = mul_a * mul_b;
wire [63:0] h2_p = {32'h0000_0000, mul_p[55:24]} * {32'h0000_0000, recip};

assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire [16:0] rs = resolve(src_reg);
wire [16:0] rd = resolve(dst_reg);
wire [16:0] rc = resolve(ctrl_reg[15:0]);

// Summation setup checks.
wire        c_byte = ctrl_reg[`RSF_C_BYTE];
wire        c_bin  = ctrl_reg[`RSF_C_BIN];
wire        c_sgn  = ctrl_reg[`RSF_C_BIN] & ctrl_reg[`RSF_C_SGN];
wire        sm_off = c_byte & ctrl_reg[`RSF_C_SKIP];
wire [15:0] nb     = bcd2bin({4'h0, ctrl_reg[11:0]});
wire [15:0] nb_m1  = nb - 16'h0001;
wire [15:0] sm_sp  = c_byte ? {1'b0, nb_m1[15:1] + {14'h0000, nb_m1[0] & sm_off}} : nb_m1;
wire [15:0] sm_end = rs[15:0] + sm_sp;
wire        sm_ok  = rs[16] && rd[16] && is_bcd({4'h0, ctrl_reg[11:0]}) && (nb != 16'h0000) &&
                     (sm_end < MEM_D) && (rs[MEM_AW-1:AREA_AW] == sm_end[MEM_AW-1:AREA_AW]) && (rd[15:0] < MEM_D - 1);

// Function setup: source word, angle and segment table header.
wire [15:0] sw     = mem[rs[MEM_AW-1:0]];
wire [15:0] sw_b   = bcd2bin(sw);
wire        tr_ok  = rs[16] && rd[16] && is_bcd(sw) && (sw_b <= `RSF_ANG_MAX) && (ctrl_reg[15:1] == 15'h0000);
wire [15:0] ang    = ctrl_reg[0] ? `RSF_ANG_MAX - sw_b : sw_b;
wire [15:0] hdr    = mem[rc[MEM_AW-1:0]];
wire [15:0] c_p1   = rc[15:0] + 16'h0001;
wire [15:0] xm     = mem[c_p1[MEM_AW-1:0]];
wire [15:0] t_end  = rc[15:0] + {7'h00, hdr[7:0], 1'b0} + 16'h0004;
wire [15:0] xin    = hdr[`RSF_H_IBIN] ? sw : sw_b;
wire [15:0] xcl    = (xin > xm) ? xm : xin;
wire        pw_ok  = rc[16] && rs[16] && rd[16] && (t_end < MEM_D) &&
                     (rc[MEM_AW-1:AREA_AW] == t_end[MEM_AW-1:AREA_AW]) && (hdr[`RSF_H_IBIN] || is_bcd(sw));

// Summation item fetch.
wire [15:0] sb     = cnt_reg + {15'h0000, sm_off};
wire [15:0] s_adr  = a_src_reg + (c_byte ? {1'b0, sb[15:1]} : cnt_reg);
wire [15:0] s_word = mem[s_adr[MEM_AW-1:0]];
wire [15:0] s_item = !c_byte ? s_word : (sb[0] ? {8'h00, s_word[7:0]} : {8'h00, s_word[15:8]});
wire [31:0] s_val  = !c_bin ? {16'h0000, bcd2bin(s_item)} :
                     c_byte ? {{24{c_sgn & s_item[7]}}, s_item[7:0]} : {{16{c_sgn & s_item[15]}}, s_item};

// Segment scan: X(i) at C+2i+1, Y(i) at C+2i+2, Y0 at C+2 and X0 is zero.
wire [15:0] pb     = c_reg + {cnt_reg[14:0], 1'b0};
wire [15:0] p_xi   = pb + 16'h0001;
wire [15:0] p_yi   = pb + 16'h0002;
wire [15:0] p_xp   = pb - 16'h0001;
wire [15:0] xi     = mem[p_xi[MEM_AW-1:0]];
wire [15:0] yi     = mem[p_yi[MEM_AW-1:0]];
wire [15:0] yp     = mem[pb[MEM_AW-1:0]];
wire [15:0] xp     = (cnt_reg == 16'h0001) ? 16'h0000 : mem[p_xp[MEM_AW-1:0]];
wire [15:0] dy     = (yi >= yp) ? yi - yp : yp - yi;
wire [15:0] dx     = x_reg[15:0] - xp;
wire [15:0] den    = xi - xp;
wire        hit    = (x_reg[15:0] <= xi) || (cnt_reg == n_reg);

wire [16:0] rem_sh = {rem_reg[15:0], num_reg[31]};
wire        rem_ge = rem_sh >= {1'b0, den_reg};
wire [15:0] q      = num_reg[15:0];
wire [15:0] y      = dneg_reg ? yb_reg - q : yb_reg + q;
wire [31:0] y_bcd  = bin2bcd({11'h000, y});
wire [31:0] s_bcd  = bin2bcd(acc_reg[26:0]);

always @* begin
    mul_a = 32'h0000_0000;
    mul_b = 32'h0000_0000;
    case (cnt_reg[3:0])
        4'h1:    recip = `RSF_R72;
        4'h2:    recip = `RSF_R42;
        4'h3:    recip = `RSF_R20;
        default: recip = `RSF_R6;
    endcase
    if (state_reg == S_TRIG) begin
        if (cnt_reg == 16'h0000) begin
            mul_a = x_reg;
            mul_b = x_reg;
        end else if (cnt_reg <= 16'h0004) begin
            mul_a = x2_reg;
            mul_b = acc_reg;
        end else if (cnt_reg == 16'h0005) begin
            mul_a = x_reg;
            mul_b = acc_reg;
        end else begin
            mul_a = acc_reg;
            mul_b = 32'h0000_000A;
        end
    end else if (state_reg == S_SCAN) begin
        mul_a = {16'h0000, dy};
        mul_b = {16'h0000, dx};
    end
end

// Bus slave: address and data are captured in either order, the write acts once both are held.
always @(posedge clk) begin
    if (rst) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        awaddr_reg   <= 8'h00;
        wdata_reg    <= 32'h0000_0000;
        wstrb_reg    <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `RSF_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp  <= `RSF_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        ctrl_reg     <= `RSF_CTRL_RST;
        src_reg      <= `RSF_WORD_RST;
        dst_reg      <= `RSF_WORD_RST;
        madr_reg     <= `RSF_WORD_RST;
        exec_reg     <= 1'b0;
        op_reg       <= 1'b0;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (do_wr) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `RSF_OKAY : `RSF_SLVERR;
            if (wr_ok) begin
                case (awaddr_reg)
                    `RSF_CMD: begin
                        if (wstrb_reg[0]) begin
                            op_reg   <= wdata_reg[`RSF_CMD_OP];
                            exec_reg <= wdata_reg[`RSF_CMD_EXEC];
                        end
                    end
                    `RSF_CTRL: ctrl_reg <= ctrl_new[16:0];
                    `RSF_SRC:  src_reg  <= src_new[15:0];
                    `RSF_DST:  dst_reg  <= dst_new[15:0];
                    `RSF_MADR: madr_reg <= madr_new[15:0];
                    default: ;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RSF_OKAY;
            case (s_axi_araddr)
                `RSF_CMD:  s_axi_rdata <= {29'h0000_0000, exec_reg, op_reg, 1'b0};
                `RSF_CTRL: s_axi_rdata <= {15'h0000, ctrl_reg};
                `RSF_SRC:  s_axi_rdata <= {16'h0000, src_reg};
                `RSF_DST:  s_axi_rdata <= {16'h0000, dst_reg};
                `RSF_STAT: s_axi_rdata <= {28'h000_0000, busy, neg_reg, zero_reg, err_reg};
                `RSF_MADR: s_axi_rdata <= {16'h0000, madr_reg};
                `RSF_MDAT: s_axi_rdata <= mem_rd;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RSF_SLVERR;
                end
            endcase
        end
    end
end

// Execution sequencer. A failed check only raises the error flag; zero and negative keep their values.
always @(posedge clk) begin
    if (do_wr && wr_ok && awaddr_reg == `RSF_MDAT)
        mem[madr_reg[MEM_AW-1:0]] <= mdat_new[15:0];
    if (state_reg == S_WR) begin
        mem[a_dst_reg[MEM_AW-1:0]] <= res_lo_reg;
        if (two_reg)
            mem[a_dst_reg[MEM_AW-1:0] + 1'b1] <= res_hi_reg;
    end
    if (rst) begin
        state_reg  <= S_IDLE;
        a_src_reg  <= 16'h0000;
        a_dst_reg  <= 16'h0000;
        c_reg      <= 16'h0000;
        hdr_reg    <= 16'h0000;
        n_reg      <= 16'h0000;
        cnt_reg    <= 16'h0000;
        acc_reg    <= 32'h0000_0000;
        x_reg      <= 32'h0000_0000;
        x2_reg     <= 32'h0000_0000;
        num_reg    <= 32'h0000_0000;
        rem_reg    <= 17'h0_0000;
        den_reg    <= 16'h0000;
        yb_reg     <= 16'h0000;
        dneg_reg   <= 1'b0;
        res_lo_reg <= 16'h0000;
        res_hi_reg <= 16'h0000;
        two_reg    <= 1'b0;
        err_reg    <= 1'b0;
        zero_reg   <= 1'b0;
        neg_reg    <= 1'b0;
    end else begin
        case (state_reg)
            S_IDLE: begin
                // condition gates start
                // The condition travels in the same command write as GO, so it is read from that write.
                if (start && wdata_reg[`RSF_CMD_EXEC])
                    state_reg <= S_SETUP;
            end
            S_SETUP: begin
                a_dst_reg <= rd[15:0];
                a_src_reg <= rs[15:0];
                cnt_reg   <= 16'h0000;
                acc_reg   <= 32'h0000_0000;
                res_lo_reg <= 16'h0000;
                state_reg <= S_IDLE;
                if (!op_reg) begin
                    if (!sm_ok)
                        err_reg <= 1'b1;
                    else begin
                        n_reg     <= nb;
                        state_reg <= S_SUM;
                    end
                end else if (!ctrl_reg[`RSF_CTRL_ISADR]) begin
                    if (!tr_ok)
                        err_reg <= 1'b1;
                    else begin
                        x_reg     <= {16'h0000, ang} * `RSF_RAD_TENTH;
                        state_reg <= S_TRIG;
                    end
                end else begin
                    if (!pw_ok)
                        err_reg <= 1'b1;
                    else begin
                        c_reg     <= rc[15:0];
                        hdr_reg   <= hdr;
                        n_reg     <= {8'h00, hdr[7:0]} + 16'h0001;
                        x_reg     <= {16'h0000, hdr[`RSF_H_REFL] ? xm - xcl : xcl};
                        cnt_reg   <= 16'h0001;
                        state_reg <= S_SCAN;
                    end
                end
            end
            S_SUM: begin
                if (!c_bin && !is_bcd(s_item)) begin
                    err_reg   <= 1'b1;
                    state_reg <= S_IDLE;
                end else begin
                    acc_reg <= acc_reg + s_val;
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == n_reg - 16'h0001)
                        state_reg <= S_SFIN;
                end
            end
            S_SFIN: begin
                res_lo_reg <= c_bin ? acc_reg[15:0] : s_bcd[15:0];
                res_hi_reg <= c_bin ? acc_reg[31:16] : s_bcd[31:16];
                two_reg    <= 1'b1;
                state_reg  <= S_WR;
            end
            S_TRIG: begin
                cnt_reg <= cnt_reg + 16'h0001;
                if (cnt_reg == 16'h0000) begin
                    x2_reg  <= mul_p[55:24];
                    acc_reg <= `RSF_ONE;
                end else if (cnt_reg <= 16'h0004) begin
                    acc_reg <= `RSF_ONE - h2_p[55:24];
                end else if (cnt_reg == 16'h0005) begin
                    acc_reg <= (mul_p[55:24] >= `RSF_ONE) ? `RSF_ONE - 32'h0000_0001 : mul_p[55:24];
                end else begin
                    acc_reg    <= {8'h00, mul_p[23:0]};
                    res_lo_reg <= {res_lo_reg[11:0], mul_p[27:24]};
                    if (cnt_reg == 16'h0009) begin
                        two_reg   <= 1'b0;
                        state_reg <= S_WR;
                    end
                end
            end
            S_SCAN: begin
                cnt_reg <= cnt_reg + 16'h0001;
                if (hit) begin
                    // A vertical segment zeroes the numerator, yet dividing it by zero still gives a quotient of FFFF.
                    num_reg   <= (den == 16'h0000) ? 32'h0000_0000 : mul_p[31:0];
                    den_reg   <= den;
                    yb_reg    <= yp;
                    dneg_reg  <= yi < yp;
                    rem_reg   <= 17'h0_0000;
                    cnt_reg   <= 16'h0000;
                    state_reg <= S_DIV;
                end
            end
            S_DIV: begin
                rem_reg <= rem_ge ? rem_sh - {1'b0, den_reg} : rem_sh;
                num_reg <= {num_reg[30:0], rem_ge};
                cnt_reg <= cnt_reg + 16'h0001;
                if (cnt_reg == 16'h001F)
                    state_reg <= S_PFIN;
            end
            S_PFIN: begin
                two_reg   <= 1'b0;
                state_reg <= S_WR;
                if (hdr_reg[`RSF_H_OBIN])
                    res_lo_reg <= y;
                else if (y > `RSF_BCD_MAX) begin
                    err_reg   <= 1'b1;
                    state_reg <= S_IDLE;
                end else
                    res_lo_reg <= y_bcd[15:0];
            end
            S_WR: begin
                err_reg   <= 1'b0;
                zero_reg  <= two_reg ? ({res_hi_reg, res_lo_reg} == 32'h0000_0000) : (res_lo_reg == 16'h0000);
                neg_reg   <= res_lo_reg[15];
                state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
        endcase
    end
end

endmodule

//--- verification/rsf_master.sv
// Register bus master standing in for the instruction sequencer.
`timescale 1ns/1ns
module rsf_master (
    input             clk,
    output reg [7:0]  awaddr,
    output reg        awvalid,
    input             awready,
    output reg [31:0] wdata,
    output reg        wvalid,
    input             wready,
    output reg        bready,
    input             bvalid,
    input      [1:0]  bresp,
    output reg [7:0]  araddr,
    output reg        arvalid,
    input             arready,
    output reg        rready,
    input             rvalid,
    input      [31:0] rdata,
    input      [1:0]  rresp
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = 43'h0;
        {araddr, arvalid, rready} = 10'h0;
    end
    // Each call starts right after a rising edge and ends on the answering edge.
    // An idle edge first keeps one call's release and the next call's request apart.
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid);
            bready <= 1'b0;
            r = bresp;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
            end while (!rvalid);
            rready <= 1'b0;
            d = rdata;
            r = rresp;
        end
    endtask
endmodule

//--- verification/rsf_unit_checker.sv
// Bus handshake and read response assertions for the range-sum and function unit.
`timescale 1ns/1ns
module rsf_unit_checker (
    input wire        clk,
    input wire        rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response withdrawn early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data withdrawn early");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
        else $error("bus not idle after reset");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
    a_stat_pad: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
        |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:4] == 28'h000_0000) else $error("status padding wrong");
endmodule
bind rsf_unit rsf_unit_checker i_rsf_unit_checker (.*);

//--- verification/rsf_unit_tb.sv
// Self-checking bench for the range-sum and function unit.
`timescale 1ns/1ns
module rsf_unit_tb;
    reg         clk, rst;
    wire [7:0]  aa, ra;
    wire [31:0] wd, rd;
    wire        av, ar, wv, wr, bv, br, rv2, rr2, rv, rr;
    wire [1:0]  bs, rs;
    integer     n_errors, num_checks, cyc;
    reg  [31:0] v;
    reg  [1:0]  r;
    rsf_unit i_rsf_unit (.clk(clk), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(ar),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bs),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(rv2), .s_axi_arready(rr2),
        .s_axi_rdata(rd), .s_axi_rresp(rs), .s_axi_rvalid(rv), .s_axi_rready(rr));
    rsf_master i_rsf_master (.clk(clk), .awaddr(aa), .awvalid(av), .awready(ar), .wdata(wd), .wvalid(wv),
        .wready(wr), .bready(br), .bvalid(bv), .bresp(bs), .araddr(ra), .arvalid(rv2), .arready(rr2),
        .rready(rr), .rvalid(rv), .rdata(rd), .rresp(rs));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [63:0] what);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task w(input [7:0] a, input [31:0] d);
        i_rsf_master.wr(a, d, r);
    endtask
    task mw(input [7:0] a, input [15:0] d);
        begin
            w(8'h14, {24'h00_0000, a});
            w(8'h18, {16'h0000, d});
        end
    endtask
    task mchk(input [7:0] a, input [15:0] d);
        begin
            w(8'h14, {24'h00_0000, a});
            i_rsf_master.rd(8'h18, v, r);
            chk(v, {16'h0000, d}, "memword");
        end
    endtask
    // Busy is polled rather than waited out, so a slow path only costs time until the watchdog at cycle 20000 fails the test.
    task fin(input [2:0] st);
        begin
            v = 32'h0000_0008;
            while (v[3] !== 1'b0) i_rsf_master.rd(8'h10, v, r);
            chk(v, {29'h0000_0000, st}, "status");
        end
    endtask
    task run(input [2:0] cmd, input [16:0] c, input [7:0] s, input [2:0] st);
        begin
            w(8'h04, {15'h0000, c});
            w(8'h08, {24'h00_0000, s});
            w(8'h0C, 32'h0000_0030);
            w(8'h00, {29'h0000_0000, cmd});
            fin(st);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end
    initial begin
        {n_errors, num_checks, cyc} = 96'h0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        mw(8'h30, 16'h1234);
        mw(8'h14, 16'h0000);
        run(3'h1, 17'h0_0003, 8'h10, 3'h0);
        run(3'h3, 17'h0_0000, 8'h14, 3'h0);
        mchk(8'h30, 16'h1234);
        mw(8'h10, 16'h0999);
        mw(8'h11, 16'h0001);
        mw(8'h12, 16'h9000);
        run(3'h5, 17'h0_8003, 8'h10, 3'h0);
        mchk(8'h30, 16'h0000);
        mchk(8'h31, 16'h0001);
        mw(8'h10, 16'h8102);
        mw(8'h11, 16'h0304);
        run(3'h5, 17'h0_7003, 8'h10, 3'h0);
        mchk(8'h30, 16'h0009);
        run(3'h5, 17'h0_E003, 8'h10, 3'h4);
        mchk(8'h31, 16'hFFFF);
        mw(8'h13, 16'h0000);
        mw(8'h16, 16'h0000);
        mw(8'h15, 16'h00A0);
        run(3'h5, 17'h0_4001, 8'h13, 3'h2);
        w(8'h08, 32'h0000_8015);
        w(8'h00, 32'h0000_0005);
        fin(3'h3);
        run(3'h5, 17'h0_4001, 8'h16, 3'h2);
        run(3'h5, 17'h0_0000, 8'h10, 3'h3);
        mw(8'h13, 16'h00A0);
        run(3'h5, 17'h0_4001, 8'h16, 3'h2);
        run(3'h5, 17'h0_0001, 8'h13, 3'h3);
        run(3'h5, 17'h0_4001, 8'h16, 3'h2);
        run(3'h5, 17'h0_0003, 8'h3E, 3'h3);
        mw(8'h14, 16'h0900);
        run(3'h7, 17'h0_0000, 8'h14, 3'h4);
        mchk(8'h30, 16'h9999);
        mw(8'h14, 16'h0000);
        run(3'h7, 17'h0_0001, 8'h14, 3'h4);
        mchk(8'h30, 16'h9999);
        run(3'h7, 17'h0_0002, 8'h14, 3'h5);
        run(3'h7, 17'h0_0001, 8'h14, 3'h4);
        mw(8'h14, 16'h0901);
        run(3'h7, 17'h0_0000, 8'h14, 3'h5);
        mw(8'h20, 16'hC000);
        mw(8'h21, 16'h0010);
        mw(8'h22, 16'h0000);
        mw(8'h23, 16'h0010);
        mw(8'h24, 16'h0100);
        mw(8'h14, 16'h0008);
        run(3'h7, 17'h1_0020, 8'h14, 3'h0);
        mchk(8'h30, 16'h0080);
        mw(8'h3E, 16'h0001);
        run(3'h7, 17'h1_003E, 8'h14, 3'h1);
        i_rsf_master.rd(8'h1C, v, r);
        chk({30'h0, r}, 32'h0000_0002, "rresp");
        w(8'h10, 32'h0000_0000);
        chk({30'h0, r}, 32'h0000_0002, "bresp");
        stop_test;
    end
endmodule
